// >>> inc/conv_regs_map.svh
// Notes on behaviour
// - phase bit: clear 120 deg, set 180 deg
// - 180 deg holds only primary to first secondary
// - span field sets setpoint step, reset 10
// - soft-start field sets ramp time, reset 10
// - software writes zeros to control_three reserved bits
// - droop bit enables droop compensation
// - standalone bit kills enable pulldown and follower clock
// - never set standalone while stacked
// - blanking bit floats power-good during transitions
// - software ignores status bits 7-6
// - hiccup flag sticky until status read
// - current limit flag sticky until read
// - thermal warning flag sticky until read
// - thermal shutdown flag sticky until read
// - undervoltage flag sticky until read
// - overvoltage flag sticky until read
// - rewrite setpoint after changing span
`ifndef CONV_REGS_MAP_SVH
`define CONV_REGS_MAP_SVH
`define ADDR_SETPOINT 3'h0
`define ADDR_CONTROL_TWO 3'h2
`define ADDR_CONTROL_THREE 3'h3
`define ADDR_EVENT_FLAGS 3'h4
`define RST_CONTROL_TWO 8'h0a
`define RST_CONTROL_THREE 8'h00
`define RST_EVENT_FLAGS 8'h00
`define CTL2_RSVD_MASK 8'h1f
`define CTL3_RSVD_MASK 8'h07
`define FLAG_MASK 8'h3f
`define BIT_PHASE 4
`define BIT_SPAN_HI 3
`define BIT_SPAN_LO 2
`define BIT_SS_HI 1
`define BIT_SS_LO 0
`define BIT_DROOP 2
`define BIT_STANDALONE 1
`define BIT_BLANK 0
`define BIT_HICCUP 5
`define BIT_OVERCURRENT 4
`define BIT_HEAT_WARN 3
`define BIT_HEAT_SHUT 2
`define BIT_OUT_LOW 1
`define BIT_OUT_HIGH 0
`define SS_TIME_0_US 500
`define SS_TIME_1_US 770
`define SS_TIME_2_US 1000
`define SS_TIME_3_US 2000
`define CLK_MHZ 125
`endif

// >>> inc/conv_regs_pkg.sv
package conv_regs_pkg;
	typedef enum logic [1:0] {
		span_1p25mv = 2'b00,
		span_2p5mv = 2'b01,
		span_5mv = 2'b10,
		span_5mv_alt = 2'b11
	} span_t;
	typedef enum logic [1:0] {
		host_idle = 2'b00,
		host_write = 2'b01,
		host_read = 2'b10,
		host_done = 2'b11
	} host_state_t;
endpackage : conv_regs_pkg

// >>> inc/conv_reg_if.sv
`timescale 1ns/1ns
interface conv_reg_if;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic rvalid;
	modport device (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
	modport host (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
endinterface : conv_reg_if

// >>> hw/conv_regs_device.sv
`timescale 1ns/1ns
`include "conv_regs_map.svh"
module conv_regs_device
	import conv_regs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	conv_reg_if.device bus,
	input wire logic hiccup_evt,
	input wire logic overcurrent_evt,
	input wire logic heat_warn_evt,
	input wire logic heat_shut_evt,
	input wire logic out_low_evt,
	input wire logic out_high_evt,
	input wire logic window_ok,
	input wire logic voltage_transition,
	output logic follower_phase_180,
	output logic [1:0] voltage_span_field,
	output logic [3:0] setpoint_step_x4,
	output logic [1:0] softstart_duration,
	output logic [17:0] softstart_cycles,
	output logic droop_comp_on,
	output logic pgood_blank_on_slew,
	output logic en_pulldown_on,
	output logic follower_clk_on,
	output logic power_good_output,
	output logic power_good_oe
);
	typedef struct packed {
		logic [7:0] control_two;
		logic [7:0] control_three;
		logic [7:0] event_flags;
		logic [7:0] rdata;
		logic rvalid;
	} state_t;
	state_t s_r, s_nxt;
	logic [7:0] events;
	////////////////////////////////////////////////////////////////
	function automatic logic [17:0] ss_cycles(input logic [1:0] code);
		int us;
		us = (code == 2'b00) ? `SS_TIME_0_US : (code == 2'b01) ? `SS_TIME_1_US :
			(code == 2'b10) ? `SS_TIME_2_US : `SS_TIME_3_US;
		return 18'(us * `CLK_MHZ);
	endfunction : ss_cycles
	////////////////////////////////////////////////////////////////
	always_comb
	begin
		events = 8'h00;
		events[`BIT_HICCUP] = hiccup_evt;
		events[`BIT_OVERCURRENT] = overcurrent_evt;
		events[`BIT_HEAT_WARN] = heat_warn_evt;
		events[`BIT_HEAT_SHUT] = heat_shut_evt;
		events[`BIT_OUT_LOW] = out_low_evt;
		events[`BIT_OUT_HIGH] = out_high_evt;
		s_nxt = s_r;
		s_nxt.rvalid = bus.rd;
		if (bus.wr)
		begin
			// reserved bits are stored as written; software keeps them zero
			if (bus.addr == `ADDR_CONTROL_TWO)
				s_nxt.control_two = bus.wdata;
			if (bus.addr == `ADDR_CONTROL_THREE)
				s_nxt.control_three = bus.wdata;
		end
		if (bus.rd)
		begin
			unique case (bus.addr)
				`ADDR_CONTROL_TWO: s_nxt.rdata = s_r.control_two;
				`ADDR_CONTROL_THREE: s_nxt.rdata = s_r.control_three;
				`ADDR_EVENT_FLAGS: s_nxt.rdata = s_r.event_flags & `FLAG_MASK;
				default: s_nxt.rdata = 8'h00;
			endcase
		end
		// clearing read then new events; a same-cycle event survives
		if (bus.rd && bus.addr == `ADDR_EVENT_FLAGS)
			s_nxt.event_flags = 8'h00;
		s_nxt.event_flags = (s_nxt.event_flags | events) & `FLAG_MASK;
	end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			s_r <= '{`RST_CONTROL_TWO, `RST_CONTROL_THREE, `RST_EVENT_FLAGS, 8'h00, 1'b0};
		else
			s_r <= s_nxt;
	end
	////////////////////////////////////////////////////////////////
	assign bus.rdata = s_r.rdata;
	assign bus.rvalid = s_r.rvalid;
	assign follower_phase_180 = s_r.control_two[`BIT_PHASE];
	assign voltage_span_field = s_r.control_two[`BIT_SPAN_HI:`BIT_SPAN_LO];
	// step in units of 1.25 mV: 1, 2, 4, 4
	assign setpoint_step_x4 = (voltage_span_field == span_1p25mv) ? 4'h1 :
		(voltage_span_field == span_2p5mv) ? 4'h2 : 4'h4;
	assign softstart_duration = s_r.control_two[`BIT_SS_HI:`BIT_SS_LO];
	assign softstart_cycles = ss_cycles(softstart_duration);
	assign droop_comp_on = s_r.control_three[`BIT_DROOP];
	assign en_pulldown_on = !s_r.control_three[`BIT_STANDALONE];
	assign follower_clk_on = !s_r.control_three[`BIT_STANDALONE];
	assign pgood_blank_on_slew = s_r.control_three[`BIT_BLANK];
	// open-drain: drive low only when window not ok, release while blanked
	assign power_good_output = 1'b0;
	assign power_good_oe = !window_ok && !(pgood_blank_on_slew && voltage_transition);
endmodule : conv_regs_device

// >>> hw/conv_regs_host.sv
`timescale 1ns/1ns
`include "conv_regs_map.svh"
module conv_regs_host
	import conv_regs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	conv_reg_if.host bus,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [2:0] req_addr,
	input wire logic [7:0] req_wdata,
	input wire logic stacked,
	output logic req_ready,
	output logic [7:0] resp_data,
	output logic resp_valid
);
	typedef struct packed {
		host_state_t st;
		logic [2:0] addr;
		logic [7:0] wdata;
		logic [7:0] resp;
		logic resp_v;
	} state_t;
	state_t s_r, s_nxt;
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] sanitize(input logic [2:0] a, input logic [7:0] d, input logic stk);
		logic [7:0] v;
		v = d;
		if (a == `ADDR_CONTROL_TWO)
			v = d & `CTL2_RSVD_MASK;
		if (a == `ADDR_CONTROL_THREE)
		begin
			v = d & `CTL3_RSVD_MASK;
			if (stk)
				v[`BIT_STANDALONE] = 1'b0;
		end
		return v;
	endfunction : sanitize
	// are system-level duties left to the command issuer
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.resp_v = 1'b0;
		unique case (s_r.st)
			host_idle:
				if (req_valid)
				begin
					s_nxt.addr = req_addr;
					s_nxt.wdata = sanitize(req_addr, req_wdata, stacked);
					s_nxt.st = req_write ? host_write : host_read;
				end
			host_write:
			begin
				s_nxt.resp_v = 1'b1;
				s_nxt.st = host_idle;
			end
			host_read: s_nxt.st = host_done;
			host_done:
				if (bus.rvalid)
				begin
					s_nxt.resp = bus.rdata & ((s_r.addr == `ADDR_EVENT_FLAGS) ? `FLAG_MASK : 8'hff);
					s_nxt.resp_v = 1'b1;
					s_nxt.st = host_idle;
				end
		endcase
	end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			s_r <= '{host_idle, 3'h0, 8'h00, 8'h00, 1'b0};
		else
			s_r <= s_nxt;
	end
	assign bus.addr = s_r.addr;
	assign bus.wdata = s_r.wdata;
	assign bus.wr = (s_r.st == host_write);
	assign bus.rd = (s_r.st == host_read);
	assign req_ready = (s_r.st == host_idle);
	assign resp_data = s_r.resp;
	assign resp_valid = s_r.resp_v;
endmodule : conv_regs_host

// >>> testbench/conv_regs_sva.sv
`timescale 1ns/1ns
module conv_regs_sva (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	logic [7:0] ctl2_r;
	logic [7:0] ctl3_r;
	// shadow of host writes; reserved bits already arrive masked
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			ctl2_r <= 8'h0a;
		else if (wr && addr == 3'h2)
			ctl2_r <= wdata;
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			ctl3_r <= 8'h00;
		else if (wr && addr == 3'h3)
			ctl3_r <= wdata;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_read_answered: assert property (rd |=> rvalid) else $error("read unanswered");
	a_no_stray_valid: assert property (!rd |=> !rvalid) else $error("stray rvalid");
	a_ctl2_readback: assert property (rd && addr == 3'h2 |=> rdata == ctl2_r) else $error("ctl2 read");
	a_ctl3_readback: assert property (rd && addr == 3'h3 |=> rdata == ctl3_r) else $error("ctl3 read");
	a_status_top_zero: assert property (rd && addr == 3'h4 |=> rdata[7:6] == 2'b00) else $error("top");
	a_ctl2_rsvd_zero: assert property (wr && addr == 3'h2 |-> wdata[7:5] == 3'h0) else $error("ctl2 rsvd");
	a_ctl3_rsvd_zero: assert property (wr && addr == 3'h3 |-> wdata[7:3] == 5'h00) else $error("ctl3 rsvd");
	a_unmapped_zero: assert property (rd && addr > 3'h4 |=> rdata == 8'h00) else $error("unmapped");
endmodule : conv_regs_sva

// >>> testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic ref_clk, rst, window_ok, voltage_transition, req_valid, req_write, stacked, req_ready, resp_valid;
	logic follower_phase_180, droop_comp_on, pgood_blank_on_slew, en_pulldown_on, follower_clk_on;
	logic power_good_output, power_good_oe;
	logic [1:0] voltage_span_field, softstart_duration;
	logic [3:0] setpoint_step_x4;
	logic [17:0] softstart_cycles;
	logic [2:0] req_addr;
	logic [7:0] req_wdata, resp_data;
	logic [5:0] evt;
	int n_fail, check_count;
	conv_reg_if bus_if();
	conv_regs_device i_conv_regs_device (.ref_clk, .rst, .bus(bus_if), .hiccup_evt(evt[5]),
		.overcurrent_evt(evt[4]), .heat_warn_evt(evt[3]), .heat_shut_evt(evt[2]), .out_low_evt(evt[1]),
		.out_high_evt(evt[0]), .window_ok, .voltage_transition, .follower_phase_180, .voltage_span_field,
		.setpoint_step_x4, .softstart_duration, .softstart_cycles, .droop_comp_on, .pgood_blank_on_slew,
		.en_pulldown_on, .follower_clk_on, .power_good_output, .power_good_oe);
	conv_regs_host i_conv_regs_host (.ref_clk, .rst, .bus(bus_if), .req_valid, .req_write, .req_addr,
		.req_wdata, .stacked, .req_ready, .resp_data, .resp_valid);
	conv_regs_sva i_sva (.ref_clk, .rst, .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
		.rd(bus_if.rd), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic chk(string what, logic [17:0] exp, logic [17:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	// one request at a time; the host takes nothing until its answer is out
	task automatic xfer(logic w, logic [2:0] a, logic [7:0] d);
		int n;
		n = 0;
		@(negedge ref_clk);
		while ((req_ready !== 1'b1 || resp_valid === 1'b1) && n < 20)
		begin
			@(negedge ref_clk);
			n++;
		end
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(negedge ref_clk);
		req_valid = 1'b0;
		while (resp_valid !== 1'b1 && n < 20)
		begin
			@(negedge ref_clk);
			n++;
		end
		if (resp_valid !== 1'b1)
		begin
			n_fail++;
			close_out();
		end
	endtask : xfer
	task automatic rd_chk(string what, logic [2:0] a, logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		chk(what, 18'(e), 18'(resp_data));
	endtask : rd_chk
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_ctl2();
		int cyc[4] = '{62500, 96250, 125000, 250000};
		int step[4] = '{1, 2, 4, 4};
		logic [7:0] d;
		for (int i = 0; i < 4; i++)
		begin
			d = {3'h7, i[0], i[1:0], 2'(3 - i)};
			xfer(1'b1, 3'h2, d);
			rd_chk("ctl2", 3'h2, d & 8'h1f);
			chk("phase", 18'(i[0]), 18'(follower_phase_180));
			chk("span", 18'(i[1:0]), 18'(voltage_span_field));
			chk("step", 18'(step[i]), 18'(setpoint_step_x4));
			chk("ssdur", 18'(3 - i), 18'(softstart_duration));
			chk("ss", 18'(cyc[3 - i]), softstart_cycles);
		end
		$display("t_ctl2 done");
	endtask : t_ctl2
	task automatic t_ctl3();
		xfer(1'b1, 3'h3, 8'hff);
		rd_chk("ctl3", 3'h3, 8'h07);
		chk("droop", 18'h1, 18'(droop_comp_on));
		chk("alone", 18'h0, 18'({en_pulldown_on, follower_clk_on}));
		chk("blanken", 18'h1, 18'(pgood_blank_on_slew));
		chk("pgout", 18'h0, 18'(power_good_output));
		window_ok = 1'b0;
		voltage_transition = 1'b1;
		@(negedge ref_clk);
		chk("blank", 18'h0, 18'(power_good_oe));
		stacked = 1'b1;
		xfer(1'b1, 3'h3, 8'h02);
		rd_chk("stack", 3'h3, 8'h00);
		chk("pull", 18'h3, 18'({en_pulldown_on, follower_clk_on}));
		chk("droopoff", 18'h0, 18'({droop_comp_on, pgood_blank_on_slew}));
		chk("follow", 18'h1, 18'(power_good_oe));
		window_ok = 1'b1;
		stacked = 1'b0;
		@(negedge ref_clk);
		chk("window", 18'h0, 18'(power_good_oe));
		voltage_transition = 1'b0;
		$display("t_ctl3 done");
	endtask : t_ctl3
	task automatic t_flags();
		for (int i = 0; i < 6; i++)
		begin
			evt = 6'h01 << i;
			@(negedge ref_clk);
			evt = 6'h00;
			rd_chk("flag", 3'h4, 8'h01 << i);
			rd_chk("clear", 3'h4, 8'h00);
		end
		// event held across the clearing read must survive it
		evt = 6'h20;
		rd_chk("held", 3'h4, 8'h20);
		evt = 6'h00;
		rd_chk("kept", 3'h4, 8'h20);
		rd_chk("gone", 3'h4, 8'h00);
		$display("t_flags done");
	endtask : t_flags
	// one-cycle event lands exactly on the clearing edge; a clear-wins bug loses it
	task automatic t_race();
		int n;
		n = 0;
		@(negedge ref_clk);
		req_valid = 1'b1;
		req_write = 1'b0;
		req_addr = 3'h4;
		@(negedge ref_clk);
		req_valid = 1'b0;
		evt = 6'h01;
		@(negedge ref_clk);
		evt = 6'h00;
		while (resp_valid !== 1'b1 && n < 20)
		begin
			@(negedge ref_clk);
			n++;
		end
		if (resp_valid !== 1'b1)
		begin
			n_fail++;
			close_out();
		end
		chk("race", 18'h0, 18'(resp_data));
		rd_chk("survive", 3'h4, 8'h01);
		$display("t_race done");
	endtask : t_race
	task automatic t_defaults();
		rd_chk("rst2", 3'h2, 8'h0a);
		rd_chk("rst3", 3'h3, 8'h00);
		rd_chk("rst4", 3'h4, 8'h00);
		rd_chk("unmap", 3'h5, 8'h00);
		$display("t_defaults done");
	endtask : t_defaults
	// reset in mid-run must bring back every default and drop pending flags
	task automatic t_reset();
		xfer(1'b1, 3'h2, 8'h15);
		xfer(1'b1, 3'h3, 8'h07);
		evt = 6'h3f;
		@(negedge ref_clk);
		evt = 6'h00;
		rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		chk("rphase", 18'h0, 18'(follower_phase_180));
		chk("rss", 18'h1e848, softstart_cycles);
		chk("rdroop", 18'h0, 18'({droop_comp_on, pgood_blank_on_slew}));
		chk("ralone", 18'h3, 18'({en_pulldown_on, follower_clk_on}));
		t_defaults();
		$display("t_reset done");
	endtask : t_reset
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial
	begin
		{rst, window_ok} = 2'b11;
		{voltage_transition, req_valid, req_write, stacked, evt} = '0;
		{req_addr, req_wdata, n_fail, check_count} = '0;
		repeat (20) @(negedge ref_clk);
		rst = 1'b0;
		t_defaults();
		t_ctl2();
		t_ctl3();
		t_flags();
		t_race();
		t_reset();
		close_out();
	end
endmodule : testbench
